// ### rtl/erb_rx_extra_bits_regs.svh
// Register offsets, field positions, reset values and limits of the receive extra-bits block
`ifndef ERB_RX_EXTRA_BITS_REGS_SVH
`define ERB_RX_EXTRA_BITS_REGS_SVH
`define ERB_OFF_EXTRA 8'h00
`define ERB_OFF_INT_STAT 8'h01
`define ERB_OFF_INT_CLR 8'h02
`define ERB_OFF_INT_EN 8'h03
`define ERB_BIT_IN_FRAME 7
`define ERB_BIT_STRICT 6
`define ERB_BIT_AIS 5
`define ERB_BIT_MASK 4
`define ERB_CTRL_RESET 1'b0
`define ERB_BYTE_RESET 8'h00
`define ERB_NIB_RESET 4'h0
`define ERB_CRC_CFG_ACTIVE 2'h3
`define ERB_WIN_ERR_LIMIT 10'h393
`define ERB_WIN_ERR_LAST 10'h392
`define ERB_WIN_ERR_ZERO 10'h000
`define ERB_WIN_ERR_ONE 10'h001
`define ERB_CONSEC_LIMIT 3'h4
`define ERB_CONSEC_LAST 3'h3
`define ERB_CONSEC_ZERO 3'h0
`define ERB_CONSEC_ONE 3'h1
`define ERB_CLK_HZ 20000000
`define ERB_LOSS_WINDOW_S 1
`define ERB_SEC_ZERO 25'h0000000
`define ERB_SEC_ONE 25'h0000001
`endif

// ### rtl/erb_pkg.sv
// Types shared by the receive extra-bits block
package erb_pkg;
   // CRC-4 multiframe alignment supervision, one-hot
   typedef enum logic [1:0] {
      ERB_CRC_ALIGNED = 2'b01,
      ERB_CRC_LOST = 2'b10
   } erb_crc_state_t;
   // Register address and data widths
   typedef logic [7:0] erb_addr_t;
   typedef logic [7:0] erb_data_t;
endpackage

// ### rtl/erb_rx_extra_bits.sv
// Receive extra-bits status and control register with CRC-4 loss supervision
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "erb_rx_extra_bits_regs.svh"

module erb_rx_extra_bits #(
   // One-second window in clock cycles; shorten in simulation
   parameter int unsigned ONE_SEC_CYCLES = `ERB_LOSS_WINDOW_S * `ERB_CLK_HZ
) (
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire erb_pkg::erb_addr_t reg_addr,
   input wire erb_pkg::erb_data_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output erb_pkg::erb_data_t reg_rdata,
   output logic irq,
   // Frame synchroniser state and alarm events
   input wire logic in_frame,
   input wire logic lof_alarm,
   input wire logic in_frame_alarm,
   input wire logic frame_alignment_change_alarm,
   input wire logic multiframe_alignment_change_alarm,
   input wire logic frame_error_alarm,
   input wire logic signalling_error_alarm,
   input wire logic framing_mode_detect_alarm,
   // CRC-4 checker events
   input wire logic [1:0] crc_multiframe_config,
   input wire logic crc_error,
   input wire logic crc_mf_done,
   input wire logic crc_mf_errored,
   input wire logic crc_mf_regained,
   output logic crc_mf_lost,
   // Timeslot 16 of frame 0 of the signalling multiframe
   input wire logic ts16_f0_strobe,
   input wire logic [7:0] ts16_f0_byte,
   // Receive serial path
   input wire logic rx_serial_in,
   output logic rx_serial_out
);
   import erb_pkg::*;

   // Control bits written by software
   logic strict_crc_loss_select_reg;
   logic rx_all_ones_insert_reg;
   logic framing_alarm_mask_reg;
   // Sampled alignment state
   logic in_frame_reg;
   // Captured bits 5..8 of timeslot 16, frame 0
   logic [3:0] ts16_bits_reg;
   // Interrupt status, enable
   logic [7:0] int_stat_reg;
   logic [7:0] int_en_reg;
   logic [7:0] int_stat_next;
   logic [7:0] int_events;
   logic [7:0] int_clr;
   // Read data and outputs
   erb_data_t rdata_reg;
   logic irq_reg;
   logic rx_serial_out_reg;
   logic crc_mf_lost_reg;
   // CRC-4 supervision
   erb_crc_state_t crc_state_reg;
   erb_crc_state_t crc_state_next;
   logic [24:0] sec_cnt_reg;
   logic [9:0] win_err_cnt_reg;
   logic [2:0] consec_cnt_reg;
   logic sec_wrap;
   logic crc_active;
   logic win_hit;
   logic consec_hit;
   logic crc_loss_event;
   // Decoded strobes
   logic wr_extra;
   logic wr_clr;
   logic wr_en;

   assign wr_extra = reg_wr && (reg_addr == `ERB_OFF_EXTRA);
   assign wr_clr = reg_wr && (reg_addr == `ERB_OFF_INT_CLR);
   assign wr_en = reg_wr && (reg_addr == `ERB_OFF_INT_EN);

   // Control bits; only these three take written data
   always_ff @(posedge clk) begin
      if (srst) begin
         // Legacy criterion, no AIS, alarms unmasked
         strict_crc_loss_select_reg <= `ERB_CTRL_RESET;
         rx_all_ones_insert_reg <= `ERB_CTRL_RESET;
         framing_alarm_mask_reg <= `ERB_CTRL_RESET;
      end else if (wr_extra) begin
         strict_crc_loss_select_reg <= reg_wdata[`ERB_BIT_STRICT];
         rx_all_ones_insert_reg <= reg_wdata[`ERB_BIT_AIS];
         framing_alarm_mask_reg <= reg_wdata[`ERB_BIT_MASK];
      end
   end

   // Alignment state follows the synchroniser every cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         in_frame_reg <= `ERB_CTRL_RESET;
      end else begin
         in_frame_reg <= in_frame;
      end
   end

   // Capture bits 5..8 of the byte; bit 1 of the slot is the MSB,
   // so bits 5..8 are the low nibble. Only valid under CAS.
   always_ff @(posedge clk) begin
      if (srst) begin
         ts16_bits_reg <= `ERB_NIB_RESET;
      end else if (ts16_f0_strobe) begin
         // Software writes never reach here
         ts16_bits_reg <= ts16_f0_byte[3:0];
      end
   end

   // Serial output is registered so the insert switch cannot glitch
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_serial_out_reg <= `ERB_CTRL_RESET;
      end else if (rx_all_ones_insert_reg) begin
         // Unframed all ones replaces the received stream
         rx_serial_out_reg <= 1'b1;
      end else begin
         rx_serial_out_reg <= rx_serial_in;
      end
   end

   // Loss supervision only runs with the multiframe field at 11
   assign crc_active = (crc_multiframe_config == `ERB_CRC_CFG_ACTIVE);
   assign sec_wrap = (32'(sec_cnt_reg) >= ONE_SEC_CYCLES - 1);
   // The 915th error inside the current window
   assign win_hit = crc_error && (win_err_cnt_reg >= `ERB_WIN_ERR_LAST);
   // The fourth errored multiframe in a row
   assign consec_hit = crc_mf_done && crc_mf_errored
                       && (consec_cnt_reg >= `ERB_CONSEC_LAST);
   // Legacy ignores the consecutive count; strict takes either
   assign crc_loss_event = crc_active && (crc_state_reg == ERB_CRC_ALIGNED)
                           && (win_hit || (strict_crc_loss_select_reg && consec_hit));

   // One-second window timer; fixed windows, not sliding,
   // which trades a little accuracy for one counter
   always_ff @(posedge clk) begin
      if (srst) begin
         sec_cnt_reg <= `ERB_SEC_ZERO;
      end else if (sec_wrap) begin
         sec_cnt_reg <= `ERB_SEC_ZERO;
      end else begin
         sec_cnt_reg <= sec_cnt_reg + `ERB_SEC_ONE;
      end
   end

   // Errors in the window, saturating at the limit
   always_ff @(posedge clk) begin
      if (srst) begin
         win_err_cnt_reg <= `ERB_WIN_ERR_ZERO;
      end else if (sec_wrap) begin
         // An error on the wrap cycle opens the new window
         win_err_cnt_reg <= crc_error ? `ERB_WIN_ERR_ONE : `ERB_WIN_ERR_ZERO;
      end else if (crc_error && (win_err_cnt_reg < `ERB_WIN_ERR_LIMIT)) begin
         win_err_cnt_reg <= win_err_cnt_reg + `ERB_WIN_ERR_ONE;
      end
   end

   // Consecutive errored multiframes, saturating
   always_ff @(posedge clk) begin
      if (srst) begin
         consec_cnt_reg <= `ERB_CONSEC_ZERO;
      end else if (crc_mf_done) begin
         if (!crc_mf_errored) begin
            // A clean multiframe breaks the run
            consec_cnt_reg <= `ERB_CONSEC_ZERO;
         end else if (consec_cnt_reg < `ERB_CONSEC_LIMIT) begin
            consec_cnt_reg <= consec_cnt_reg + `ERB_CONSEC_ONE;
         end
      end
   end

   // Alignment supervision next state
   always_comb begin
      crc_state_next = crc_state_reg;
      case (crc_state_reg)
         ERB_CRC_ALIGNED: begin
            if (crc_loss_event) begin
               crc_state_next = ERB_CRC_LOST;
            end
         end
         ERB_CRC_LOST: begin
            // Regained by the synchroniser, or supervision switched off
            if (crc_mf_regained || !crc_active) begin
               crc_state_next = ERB_CRC_ALIGNED;
            end
         end
         default: begin
            crc_state_next = ERB_CRC_ALIGNED;
         end
      endcase
   end

   // Supervision state and its flop-driven output
   always_ff @(posedge clk) begin
      if (srst) begin
         crc_state_reg <= ERB_CRC_ALIGNED;
         crc_mf_lost_reg <= `ERB_CTRL_RESET;
      end else begin
         crc_state_reg <= crc_state_next;
         crc_mf_lost_reg <= (crc_state_next == ERB_CRC_LOST);
      end
   end

   // Events: seven framing alarms, gated by the mask, plus CRC loss
   always_comb begin
      int_events[0] = lof_alarm;
      int_events[1] = in_frame_alarm;
      int_events[2] = frame_alignment_change_alarm;
      int_events[3] = multiframe_alignment_change_alarm;
      int_events[4] = frame_error_alarm;
      int_events[5] = signalling_error_alarm;
      int_events[6] = framing_mode_detect_alarm;
      if (framing_alarm_mask_reg) begin
         int_events[6:0] = 7'h00;
      end
      int_events[7] = crc_loss_event;
   end

   // A set in the clearing cycle wins over the clear
   assign int_clr = wr_clr ? reg_wdata : `ERB_BYTE_RESET;
   assign int_stat_next = (int_stat_reg & ~int_clr) | int_events;

   // Sticky status and its enables
   always_ff @(posedge clk) begin
      if (srst) begin
         int_stat_reg <= `ERB_BYTE_RESET;
         int_en_reg <= `ERB_BYTE_RESET;
      end else begin
         int_stat_reg <= int_stat_next;
         if (wr_en) begin
            int_en_reg <= reg_wdata;
         end
      end
   end

   // Level interrupt, one cycle behind the status
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_reg <= `ERB_CTRL_RESET;
      end else begin
         irq_reg <= |(int_stat_reg & int_en_reg);
      end
   end

   // Read data stand for one cycle only; unmapped reads return zero
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_reg <= `ERB_BYTE_RESET;
      end else if (reg_rd) begin
         case (reg_addr)
            `ERB_OFF_EXTRA: begin
               rdata_reg <= {in_frame_reg, strict_crc_loss_select_reg,
                             rx_all_ones_insert_reg, framing_alarm_mask_reg,
                             ts16_bits_reg};
            end
            `ERB_OFF_INT_STAT: begin
               rdata_reg <= int_stat_reg;
            end
            `ERB_OFF_INT_EN: begin
               rdata_reg <= int_en_reg;
            end
            default: begin
               // Clear register is write-only
               rdata_reg <= `ERB_BYTE_RESET;
            end
         endcase
      end else begin
         rdata_reg <= `ERB_BYTE_RESET;
      end
   end

   assign reg_rdata = rdata_reg;
   assign irq = irq_reg;
   assign rx_serial_out = rx_serial_out_reg;
   assign crc_mf_lost = crc_mf_lost_reg;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   in_frame_read_a: assert property (
      (reg_rd && reg_addr == `ERB_OFF_EXTRA) ##0 $past(in_frame) |=> reg_rdata[7])
      else $error("alignment bit not read as one");
   legacy_window_a: assert property (
      (crc_active && crc_state_reg == ERB_CRC_ALIGNED && crc_error
       && win_err_cnt_reg == `ERB_WIN_ERR_LAST) |=> crc_mf_lost)
      else $error("915th error did not declare loss");
   legacy_no_consec_a: assert property (
      (crc_state_reg == ERB_CRC_ALIGNED && !strict_crc_loss_select_reg
       && !crc_error) |=> crc_state_reg == ERB_CRC_ALIGNED)
      else $error("legacy loss without error limit");
   strict_consec_a: assert property (
      (crc_active && strict_crc_loss_select_reg && crc_state_reg == ERB_CRC_ALIGNED
       && crc_mf_done && crc_mf_errored && consec_cnt_reg == `ERB_CONSEC_LAST)
      |=> crc_mf_lost ##1 crc_mf_lost || crc_state_reg == ERB_CRC_ALIGNED)
      else $error("four errored multiframes not declared");
   ais_force_a: assert property (
      rx_all_ones_insert_reg |=> rx_serial_out)
      else $error("all ones not driven");
   ais_pass_a: assert property (
      !rx_all_ones_insert_reg |=> rx_serial_out == $past(rx_serial_in))
      else $error("received data not passed");
   alarm_mask_a: assert property (
      (framing_alarm_mask_reg && int_stat_reg[6:0] == 7'h00)
      |=> int_stat_reg[6:0] == 7'h00)
      else $error("masked alarm reached status");
   ts16_capture_a: assert property (
      ts16_f0_strobe ##1 (reg_rd && reg_addr == `ERB_OFF_EXTRA && !ts16_f0_strobe)
      |=> reg_rdata[3:0] == $past(ts16_f0_byte[3:0], 2))
      else $error("timeslot 16 bits not captured");
   reset_ctrl_a: assert property (
      $past(srst) |-> !strict_crc_loss_select_reg && !rx_all_ones_insert_reg
      && !framing_alarm_mask_reg)
      else $error("control bits not zero after reset");
   write_scope_a: assert property (
      (wr_extra && !ts16_f0_strobe) |=> $stable(ts16_bits_reg))
      else $error("write changed captured bits");
   set_wins_a: assert property (
      (int_events[0] && wr_clr && reg_wdata[0]) |=> int_stat_reg[0])
      else $error("event lost under clear");

   ais_on_c: cover property (wr_extra && reg_wdata[`ERB_BIT_AIS]);
   strict_loss_c: cover property (strict_crc_loss_select_reg && consec_hit && crc_loss_event);
   irq_c: cover property (!irq ##1 irq);
   masked_alarm_c: cover property (framing_alarm_mask_reg && lof_alarm);
endmodule

// ### test/test_erb_rx_extra_bits.sv
// Self-checking bench for the receive extra-bits status and control register block
`timescale 1ns/1ps
`include "erb_rx_extra_bits_regs.svh"

module test_erb_rx_extra_bits;
   import erb_pkg::*;
   // Short one-second window so the whole loss test fits in a brief run
   localparam int unsigned SEC_CYCLES = 2000;
   // Ceiling on the run; the tests need well under a quarter of this
   localparam int TIMEOUT_CYCLES = 20000;
   logic clk = 1'b0;
   logic srst = 1'b1;
   erb_addr_t reg_addr = 8'h00;
   erb_data_t reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   erb_data_t reg_rdata;
   logic irq;
   logic in_frame = 1'b0;
   // Framing alarm events, in interrupt status bit order
   logic [6:0] alarms = 7'h00;
   logic [1:0] crc_multiframe_config = 2'h0;
   logic crc_error = 1'b0;
   logic crc_mf_done = 1'b0;
   logic crc_mf_errored = 1'b0;
   logic crc_mf_regained = 1'b0;
   logic crc_mf_lost;
   logic ts16_f0_strobe = 1'b0;
   logic [7:0] ts16_f0_byte = 8'h00;
   logic rx_serial_in = 1'b0;
   logic rx_serial_out;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   erb_data_t rd_val;

   erb_rx_extra_bits #(.ONE_SEC_CYCLES(SEC_CYCLES)) erb_rx_extra_bits_i (
      .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .in_frame(in_frame), .lof_alarm(alarms[0]), .in_frame_alarm(alarms[1]),
      .frame_alignment_change_alarm(alarms[2]),
      .multiframe_alignment_change_alarm(alarms[3]),
      .frame_error_alarm(alarms[4]), .signalling_error_alarm(alarms[5]),
      .framing_mode_detect_alarm(alarms[6]),
      .crc_multiframe_config(crc_multiframe_config), .crc_error(crc_error),
      .crc_mf_done(crc_mf_done), .crc_mf_errored(crc_mf_errored),
      .crc_mf_regained(crc_mf_regained), .crc_mf_lost(crc_mf_lost),
      .ts16_f0_strobe(ts16_f0_strobe), .ts16_f0_byte(ts16_f0_byte),
      .rx_serial_in(rx_serial_in), .rx_serial_out(rx_serial_out)
   );

   // Free-running 20 MHz clock
   always #25 clk = ~clk;

   // Verdict in one place, reached by the main sequence or the timeout
   task automatic give_verdict();
      if (n_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Hang guard: counts as a mismatch and closes the run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT_CYCLES) begin
         n_errors = n_errors + 1;
         give_verdict();
      end
   end

   // Byte comparison; case equality so an unknown never matches
   task automatic check_byte(input erb_data_t got, input erb_data_t exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Single-bit comparison for outputs such as irq and the serial line
   task automatic check_bit(input logic got, input logic exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Synchronous reset held for five edges
   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
   endtask

   // One-cycle write strobe
   task automatic reg_write(input erb_addr_t a, input erb_data_t d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle read strobe; data are taken in the single cycle they stand
   task automatic reg_read(input erb_addr_t a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask

   // One event pulse, plus an edge so the status bit has landed
   task automatic pulse_alarm(input int i);
      @(posedge clk);
      alarms <= 7'h01 << i;
      @(posedge clk);
      alarms <= 7'h00;
      @(posedge clk);
   endtask

   // A run of n back-to-back CRC-4 error pulses
   task automatic crc_errors(input int n);
      @(posedge clk);
      crc_error <= 1'b1;
      repeat (n) @(posedge clk);
      crc_error <= 1'b0;
   endtask

   // End of one CRC-4 multiframe, errored or clean
   task automatic crc_mf(input logic errored);
      @(posedge clk);
      crc_mf_done <= 1'b1;
      crc_mf_errored <= errored;
      @(posedge clk);
      crc_mf_done <= 1'b0;
      crc_mf_errored <= 1'b0;
   endtask

   // Reset values, write-only clear and an unmapped address
   task automatic test_reset_values();
      reg_read(`ERB_OFF_EXTRA);
      check_byte(rd_val, 8'h00);
      reg_read(`ERB_OFF_INT_STAT);
      check_byte(rd_val, 8'h00);
      reg_read(`ERB_OFF_INT_CLR);
      check_byte(rd_val, 8'h00);
      reg_read(8'h10);
      check_byte(rd_val, 8'h00);
   endtask

   // Only the control bits take writes; bit 7 follows the framer
   task automatic test_write_mask();
      @(posedge clk);
      in_frame <= 1'b1;
      reg_write(`ERB_OFF_EXTRA, 8'hFF);
      reg_read(`ERB_OFF_EXTRA);
      check_byte(rd_val, 8'hF0);
      @(posedge clk);
      in_frame <= 1'b0;
      reg_write(`ERB_OFF_EXTRA, 8'h8F);
      reg_read(`ERB_OFF_EXTRA);
      check_byte(rd_val, 8'h00);
   endtask

   // One-hot captures prove each slot bit lands in its own field;
   // the read follows the strobe at once, the tightest case
   task automatic test_ts16();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         ts16_f0_strobe <= 1'b1;
         ts16_f0_byte <= 8'hF0 | (8'h08 >> i);
         @(posedge clk);
         ts16_f0_strobe <= 1'b0;
         ts16_f0_byte <= 8'h0F;
         reg_rd <= 1'b1;
         reg_addr <= `ERB_OFF_EXTRA;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1;
         check_byte(reg_rdata, 8'h08 >> i);
      end
   endtask

   // Serial path: pattern with zeros, so forced ones are visible
   task automatic serial_check(input logic ais_on);
      logic [7:0] pat;
      pat = 8'h5A;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         rx_serial_in <= pat[i];
         @(posedge clk);
         #1;
         check_bit(rx_serial_out, ais_on ? 1'b1 : pat[i]);
      end
   endtask

   task automatic test_ais();
      reg_write(`ERB_OFF_EXTRA, 8'h20);
      serial_check(1'b1);
      reg_write(`ERB_OFF_EXTRA, 8'h00);
      serial_check(1'b0);
   endtask

   // Every alarm raises, clears and is suppressed by the mask
   task automatic test_alarm_mask();
      reg_write(`ERB_OFF_INT_EN, 8'h7F);
      for (int i = 0; i < 7; i++) begin
         pulse_alarm(i);
         reg_read(`ERB_OFF_INT_STAT);
         check_byte(rd_val, 8'h01 << i);
         check_bit(irq, 1'b1);
         reg_write(`ERB_OFF_INT_CLR, 8'h01 << i);
         reg_read(`ERB_OFF_INT_STAT);
         check_byte(rd_val, 8'h00);
         check_bit(irq, 1'b0);
      end
      // Event and clear in the same cycle: the set wins
      @(posedge clk);
      alarms <= 7'h01;
      reg_wr <= 1'b1;
      reg_addr <= `ERB_OFF_INT_CLR;
      reg_wdata <= 8'h01;
      @(posedge clk);
      alarms <= 7'h00;
      reg_wr <= 1'b0;
      reg_read(`ERB_OFF_INT_STAT);
      check_byte(rd_val, 8'h01);
      // A set bit with its enable off must not interrupt
      pulse_alarm(0);
      reg_write(`ERB_OFF_INT_EN, 8'h00);
      reg_read(`ERB_OFF_INT_EN);
      check_byte(rd_val, 8'h00);
      check_bit(irq, 1'b0);
      reg_write(`ERB_OFF_INT_CLR, 8'hFF);
      reg_write(`ERB_OFF_INT_EN, 8'h7F);
      reg_write(`ERB_OFF_EXTRA, 8'h10);
      for (int i = 0; i < 7; i++) begin
         pulse_alarm(i);
         reg_read(`ERB_OFF_INT_STAT);
         check_byte(rd_val, 8'h00);
         check_bit(irq, 1'b0);
      end
      reg_write(`ERB_OFF_EXTRA, 8'h00);
   endtask

   // Legacy criterion: errored multiframes ignored, 915th error declares
   task automatic test_crc_legacy();
      do_reset();
      crc_multiframe_config <= 2'h3;
      reg_write(`ERB_OFF_INT_EN, 8'h80);
      repeat (4) crc_mf(1'b1);
      crc_errors(914);
      repeat (2) @(posedge clk);
      #1;
      check_bit(crc_mf_lost, 1'b0);
      check_bit(irq, 1'b0);
      crc_errors(1);
      repeat (2) @(posedge clk);
      #1;
      check_bit(crc_mf_lost, 1'b1);
      check_bit(irq, 1'b1);
      reg_read(`ERB_OFF_INT_STAT);
      check_byte(rd_val, 8'h80);
   endtask

   // Strict criterion: four consecutive errored multiframes, only at config 11
   task automatic test_crc_strict();
      do_reset();
      reg_write(`ERB_OFF_EXTRA, 8'h40);
      crc_multiframe_config <= 2'h2;
      repeat (4) crc_mf(1'b1);
      @(posedge clk);
      #1;
      check_bit(crc_mf_lost, 1'b0);
      @(posedge clk);
      crc_multiframe_config <= 2'h3;
      // The run counter keeps counting while supervision is off,
      // so a clean multiframe starts the strict count afresh
      crc_mf(1'b0);
      crc_mf(1'b1);
      crc_mf(1'b1);
      crc_mf(1'b0);
      repeat (3) crc_mf(1'b1);
      @(posedge clk);
      #1;
      check_bit(crc_mf_lost, 1'b0);
      crc_mf(1'b1);
      @(posedge clk);
      #1;
      check_bit(crc_mf_lost, 1'b1);
      @(posedge clk);
      crc_mf_regained <= 1'b1;
      @(posedge clk);
      crc_mf_regained <= 1'b0;
      @(posedge clk);
      #1;
      check_bit(crc_mf_lost, 1'b0);
   endtask

   // Main sequence
   initial begin
      do_reset();
      test_reset_values();
      test_write_mask();
      test_ts16();
      test_ais();
      test_alarm_mask();
      test_crc_legacy();
      test_crc_strict();
      give_verdict();
   end
endmodule
